/* File: pkg/sgpio_pkg.sv */
// package: register offsets, field positions and carrier types of the shared gpio ports
`default_nettype none
package sgpio_pkg;
   localparam logic [7:0] PORT_E_DATA_OFS = 8'h08;
   localparam logic [7:0] PORT_F_DATA_OFS = 8'h09;
   localparam logic [7:0] PORT_E_DIR_OFS  = 8'h0c; // chosen offset
   localparam logic [7:0] PORT_F_DIR_OFS  = 8'h0d; // chosen offset
   localparam logic [7:0] PORT_E_DIR_RST  = 8'h00;
   localparam logic [3:0] PORT_F_DIR_RST  = 4'h0;
   localparam int E_SCK = 7;
   localparam int E_MOSI = 6;
   localparam int E_MISO = 5;
   localparam int E_SS = 4;
   localparam int E_TCH1 = 3;
   localparam int E_TCH0 = 2;
   localparam int E_RXD = 1;
   localparam int E_TXD = 0;

   // pins of one port: level driven, active-low output enable
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe_n;
   } sgpio_e_pins_t;

   typedef struct packed {
      logic [3:0] out;
      logic [3:0] oe_n;
   } sgpio_f_pins_t;

   // spi side of the port
   typedef struct packed {
      logic spi_enable_bit;
      logic spi_master_select;
      logic mode_fault_enable;
      logic sck_out;
      logic mosi_out;
      logic miso_out;
   } sgpio_spi_t;
endpackage : sgpio_pkg
`default_nettype wire

/* File: rtl/sgpio_ports.sv */
// shared general-purpose ports e (8 pins) and f (4 pins) with peripheral takeover
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module sgpio_ports (
   input  wire logic                    CLK,
   input  wire logic                    RESETN,
   input  wire logic                    CE,
   input  wire logic [7:0]              ADDR,
   input  wire logic [7:0]              WDATA,
   input  wire logic                    WR,
   input  wire logic                    RD,
   output var  logic [7:0]              RDATA,
   input  wire logic [7:0]              PE_IN,
   output var  sgpio_pkg::sgpio_e_pins_t PE_PINS,
   input  wire logic [3:0]              PF_IN,
   output var  sgpio_pkg::sgpio_f_pins_t PF_PINS,
   input  wire sgpio_pkg::sgpio_spi_t   SPI,
   output var  logic                    SPI_SCK_IN,
   output var  logic                    SPI_MOSI_IN,
   output var  logic                    SPI_MISO_IN,
   output var  logic                    SPI_SS_N_IN,
   input  wire logic                    SERIAL_ENABLE_BIT,
   input  wire logic                    SERIAL_TX,
   output var  logic                    SERIAL_RX,
   input  wire logic [5:0]              TIMER_CH_EN,
   input  wire logic [5:0]              TIMER_CH_OUT,
   input  wire logic [5:0]              TIMER_CH_OE,
   output var  logic [5:0]              TIMER_CH_IN
);

   logic [7:0] port_e_latch_reg;
   logic [7:0] port_e_dir_reg;
   logic [3:0] port_f_latch_reg;
   logic [3:0] port_f_dir_reg;
   logic [7:0] e_own;       // pin owned by a peripheral
   logic [7:0] e_per_oe;    // peripheral enable, active high
   logic [7:0] e_per_out;
   logic [7:0] e_view;
   logic [3:0] f_view;
   logic       spi_on;
   logic       spi_mst;     // spi enabled as master
   logic       spi_slv;     // spi enabled as slave
   logic       ss_used;
   logic       wr_e_data;   // write hits port e latches
   logic       wr_f_data;   // write hits port f latches
   logic       wr_e_dir;    // write hits port e direction
   logic       wr_f_dir;    // write hits port f direction
   logic [7:0] rdata_next;

   ////////////////////////////////////////////////////////////////////////////////
   // write decode

   // one hit line per register; a frozen clock enable blocks every write
   always_comb begin
      wr_e_data = CE && WR && (ADDR == sgpio_pkg::PORT_E_DATA_OFS);
      wr_f_data = CE && WR && (ADDR == sgpio_pkg::PORT_F_DATA_OFS);
      wr_e_dir  = CE && WR && (ADDR == sgpio_pkg::PORT_E_DIR_OFS);
      wr_f_dir  = CE && WR && (ADDR == sgpio_pkg::PORT_F_DIR_OFS);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // register writes

   // data latches have no reset: their content survives reset
   always_ff @(posedge CLK) begin
      if (wr_e_data) begin
         port_e_latch_reg <= WDATA;
      end
      if (wr_f_data) begin
         port_f_latch_reg <= WDATA[3:0];
      end
   end

   // direction registers clear on reset, every pin not owned by a peripheral becomes an input
   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         port_e_dir_reg <= sgpio_pkg::PORT_E_DIR_RST;
         port_f_dir_reg <= sgpio_pkg::PORT_F_DIR_RST;
      end else begin
         if (wr_e_dir) begin
            port_e_dir_reg <= WDATA;
         end
         if (wr_f_dir) begin
            port_f_dir_reg <= WDATA[3:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // pin ownership

   // slave select is gpio when spi is off, or master without mode fault
   always_comb begin
      spi_on  = SPI.spi_enable_bit;
      spi_mst = SPI.spi_enable_bit && SPI.spi_master_select;
      spi_slv = SPI.spi_enable_bit && !SPI.spi_master_select;
      ss_used = spi_on && !(SPI.spi_master_select && !SPI.mode_fault_enable);
   end

   // pin seven: spi clock, output for a master, input for a slave
   always_comb begin
      if (spi_on) begin
         e_own[sgpio_pkg::E_SCK]     = 1'b1;
         e_per_oe[sgpio_pkg::E_SCK]  = spi_mst;
         e_per_out[sgpio_pkg::E_SCK] = SPI.sck_out;
      end else begin
         e_own[sgpio_pkg::E_SCK]     = 1'b0;
         e_per_oe[sgpio_pkg::E_SCK]  = 1'b0;
         e_per_out[sgpio_pkg::E_SCK] = 1'b0;
      end
   end

   // pin six: master out, driven only by a master
   always_comb begin
      if (spi_on) begin
         e_own[sgpio_pkg::E_MOSI]     = 1'b1;
         e_per_oe[sgpio_pkg::E_MOSI]  = spi_mst;
         e_per_out[sgpio_pkg::E_MOSI] = SPI.mosi_out;
      end else begin
         e_own[sgpio_pkg::E_MOSI]     = 1'b0;
         e_per_oe[sgpio_pkg::E_MOSI]  = 1'b0;
         e_per_out[sgpio_pkg::E_MOSI] = 1'b0;
      end
   end

   // pin five: slave out, driven only by a slave
   always_comb begin
      if (spi_on) begin
         e_own[sgpio_pkg::E_MISO]     = 1'b1;
         e_per_oe[sgpio_pkg::E_MISO]  = spi_slv;
         e_per_out[sgpio_pkg::E_MISO] = SPI.miso_out;
      end else begin
         e_own[sgpio_pkg::E_MISO]     = 1'b0;
         e_per_oe[sgpio_pkg::E_MISO]  = 1'b0;
         e_per_out[sgpio_pkg::E_MISO] = 1'b0;
      end
   end

   // pin four: slave select is an input, so its direction bit is ignored
   always_comb begin
      if (ss_used) begin
         e_own[sgpio_pkg::E_SS]     = 1'b1;
         e_per_oe[sgpio_pkg::E_SS]  = 1'b0;
         e_per_out[sgpio_pkg::E_SS] = 1'b0;
      end else begin
         e_own[sgpio_pkg::E_SS]     = 1'b0;
         e_per_oe[sgpio_pkg::E_SS]  = 1'b0;
         e_per_out[sgpio_pkg::E_SS] = 1'b0;
      end
   end

   // pin three: timer channel one when its edge/level select claims it
   always_comb begin
      if (TIMER_CH_EN[1]) begin
         e_own[sgpio_pkg::E_TCH1]     = 1'b1;
         e_per_oe[sgpio_pkg::E_TCH1]  = TIMER_CH_OE[1];
         e_per_out[sgpio_pkg::E_TCH1] = TIMER_CH_OUT[1];
      end else begin
         e_own[sgpio_pkg::E_TCH1]     = 1'b0;
         e_per_oe[sgpio_pkg::E_TCH1]  = 1'b0;
         e_per_out[sgpio_pkg::E_TCH1] = 1'b0;
      end
   end

   // pin two: timer channel zero when its edge/level select claims it
   always_comb begin
      if (TIMER_CH_EN[0]) begin
         e_own[sgpio_pkg::E_TCH0]     = 1'b1;
         e_per_oe[sgpio_pkg::E_TCH0]  = TIMER_CH_OE[0];
         e_per_out[sgpio_pkg::E_TCH0] = TIMER_CH_OUT[0];
      end else begin
         e_own[sgpio_pkg::E_TCH0]     = 1'b0;
         e_per_oe[sgpio_pkg::E_TCH0]  = 1'b0;
         e_per_out[sgpio_pkg::E_TCH0] = 1'b0;
      end
   end

   // pin one: serial receive, always an input while the serial unit is on
   always_comb begin
      if (SERIAL_ENABLE_BIT) begin
         e_own[sgpio_pkg::E_RXD]     = 1'b1;
         e_per_oe[sgpio_pkg::E_RXD]  = 1'b0;
         e_per_out[sgpio_pkg::E_RXD] = 1'b0;
      end else begin
         e_own[sgpio_pkg::E_RXD]     = 1'b0;
         e_per_oe[sgpio_pkg::E_RXD]  = 1'b0;
         e_per_out[sgpio_pkg::E_RXD] = 1'b0;
      end
   end

   // pin zero: serial transmit, driven even when idle so the line rests high
   always_comb begin
      if (SERIAL_ENABLE_BIT) begin
         e_own[sgpio_pkg::E_TXD]     = 1'b1;
         e_per_oe[sgpio_pkg::E_TXD]  = 1'b1;
         e_per_out[sgpio_pkg::E_TXD] = SERIAL_TX;
      end else begin
         e_own[sgpio_pkg::E_TXD]     = 1'b0;
         e_per_oe[sgpio_pkg::E_TXD]  = 1'b0;
         e_per_out[sgpio_pkg::E_TXD] = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // pin drivers, one per pin

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_pe
         always_comb begin
            if (e_own[gi]) begin
               PE_PINS.out[gi]  = e_per_out[gi];
               PE_PINS.oe_n[gi] = !e_per_oe[gi];
            end else begin
               PE_PINS.out[gi]  = port_e_latch_reg[gi];
               PE_PINS.oe_n[gi] = !port_e_dir_reg[gi];
            end
            // read view: direction bit chooses latch or pin, even when owned
            e_view[gi] = port_e_dir_reg[gi] ? port_e_latch_reg[gi] : PE_IN[gi];
         end
      end
      for (gi = 0; gi < 4; gi++) begin : g_pf
         always_comb begin
            if (TIMER_CH_EN[gi + 2]) begin
               PF_PINS.out[gi]  = TIMER_CH_OUT[gi + 2];
               PF_PINS.oe_n[gi] = !TIMER_CH_OE[gi + 2];
            end else begin
               PF_PINS.out[gi]  = port_f_latch_reg[gi];
               PF_PINS.oe_n[gi] = !port_f_dir_reg[gi];
            end
            f_view[gi] = port_f_dir_reg[gi] ? port_f_latch_reg[gi] : PF_IN[gi];
         end
      end
   endgenerate

   // peripherals see the raw pin levels; unused slave select and serial receive (serial unit off) read high
   always_comb begin
      SPI_SCK_IN  = PE_IN[sgpio_pkg::E_SCK];
      SPI_MOSI_IN = PE_IN[sgpio_pkg::E_MOSI];
      SPI_MISO_IN = PE_IN[sgpio_pkg::E_MISO];
      SPI_SS_N_IN = ss_used ? PE_IN[sgpio_pkg::E_SS] : 1'b1;
      SERIAL_RX   = SERIAL_ENABLE_BIT ? PE_IN[sgpio_pkg::E_RXD] : 1'b1;
      TIMER_CH_IN = {PF_IN, PE_IN[sgpio_pkg::E_TCH1], PE_IN[sgpio_pkg::E_TCH0]};
   end

   ////////////////////////////////////////////////////////////////////////////////
   // register reads, data one cycle after the strobe

   always_comb begin
      unique case (ADDR)
         sgpio_pkg::PORT_E_DATA_OFS: rdata_next = e_view;
         sgpio_pkg::PORT_F_DATA_OFS: rdata_next = {4'h0, f_view};
         sgpio_pkg::PORT_E_DIR_OFS:  rdata_next = port_e_dir_reg;
         sgpio_pkg::PORT_F_DIR_OFS:  rdata_next = {4'h0, port_f_dir_reg};
         default:                    rdata_next = 8'h00; // unmapped reads zero
      endcase
   end

   // data stand from the cycle after the strobe until a later CE cycle without RD loads zero; held while CE is low
   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         RDATA <= 8'h00;
      end else if (CE) begin
         RDATA <= RD ? rdata_next : 8'h00;
      end
   end

endmodule : sgpio_ports
`default_nettype wire

/* File: sim/sgpio_pins.sv */
// pin model: driven pins read back, released pins take the outside level
`timescale 1ns/1ps
`default_nettype none
module sgpio_pins (
   input  wire sgpio_pkg::sgpio_e_pins_t e,
   input  wire sgpio_pkg::sgpio_f_pins_t f,
   input  wire logic [7:0]               ext_e,
   input  wire logic [3:0]               ext_f,
   output var  logic [7:0]               e_lvl,
   output var  logic [3:0]               f_lvl
);
   // a driven pin shows its own level, a free pin the outside one
   assign e_lvl = (e.out & ~e.oe_n) | (ext_e & e.oe_n);
   assign f_lvl = (f.out & ~f.oe_n) | (ext_f & f.oe_n);
endmodule : sgpio_pins
`default_nettype wire

/* File: sim/sgpio_ports_asserts.sv */
// checker: pin ownership and register read relations of port e
`timescale 1ns/1ps
`default_nettype none
module sgpio_ports_asserts (
   input wire logic                     CLK,
   input wire logic                     RESETN,
   input wire logic                     CE,
   input wire logic [7:0]               ADDR,
   input wire logic                     RD,
   input wire logic [7:0]               RDATA,
   input wire logic [7:0]               PE_IN,
   input wire sgpio_pkg::sgpio_e_pins_t PE_PINS,
   input wire sgpio_pkg::sgpio_spi_t    SPI,
   input wire logic                     SERIAL_ENABLE_BIT,
   input wire logic                     SERIAL_TX,
   input wire logic [5:0]               TIMER_CH_EN,
   input wire logic [5:0]               TIMER_CH_OE
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESETN);
   logic gp;
   // no peripheral claims a port e pin
   assign gp = !SPI.spi_enable_bit && !SERIAL_ENABLE_BIT && TIMER_CH_EN[1:0] == 2'h0;
   sequence s_rd_e; CE && RD && ADDR == sgpio_pkg::PORT_E_DATA_OFS && gp; endsequence
   property p_rd_e;
      s_rd_e |=> RDATA == $past((PE_PINS.out & ~PE_PINS.oe_n) | (PE_IN & PE_PINS.oe_n));
   endproperty
   property p_rst; $past(!RESETN && CE) && gp |-> PE_PINS.oe_n == 8'hff; endproperty
   property p_idle; $past(CE && !RD) |-> RDATA == 8'h00; endproperty
   property p_sck;
      SPI.spi_enable_bit && SPI.spi_master_select |-> !PE_PINS.oe_n[7] && PE_PINS.out[7] == SPI.sck_out;
   endproperty
   property p_slv;
      SPI.spi_enable_bit && !SPI.spi_master_select |-> PE_PINS.oe_n[7:4] == 4'hd;
   endproperty
   property p_ss;
      SPI.spi_enable_bit && SPI.spi_master_select && SPI.mode_fault_enable |-> PE_PINS.oe_n[4];
   endproperty
   property p_sci;
      SERIAL_ENABLE_BIT |-> PE_PINS.oe_n[1:0] == 2'h2 && PE_PINS.out[0] == SERIAL_TX;
   endproperty
   property p_tmr; TIMER_CH_EN[0] |-> PE_PINS.oe_n[2] == !TIMER_CH_OE[0]; endproperty
   a_rd_e: assert property (p_rd_e) else $error("port e read wrong");
   a_rst: assert property (p_rst) else $error("direction not cleared");
   a_idle: assert property (p_idle) else $error("read data not zero");
   a_sck: assert property (p_sck) else $error("clock pin not owned");
   a_slv: assert property (p_slv) else $error("slave pins wrong");
   a_ss: assert property (p_ss) else $error("select pin driven");
   a_sci: assert property (p_sci) else $error("serial pins wrong");
   a_tmr: assert property (p_tmr) else $error("timer pin wrong");
endmodule : sgpio_ports_asserts
bind sgpio_ports sgpio_ports_asserts sgpio_ports_asserts_inst (.CLK(CLK), .RESETN(RESETN),
   .CE(CE), .ADDR(ADDR), .RD(RD), .RDATA(RDATA), .PE_IN(PE_IN), .PE_PINS(PE_PINS), .SPI(SPI),
   .SERIAL_ENABLE_BIT(SERIAL_ENABLE_BIT), .SERIAL_TX(SERIAL_TX), .TIMER_CH_EN(TIMER_CH_EN),
   .TIMER_CH_OE(TIMER_CH_OE));
`default_nettype wire

/* File: sim/sgpio_ports_tb_top.sv */
// bench: register accesses and pin takeover by peripherals
`timescale 1ns/1ps
`default_nettype none
module sgpio_ports_tb_top;
   localparam logic [7:0] ED  = sgpio_pkg::PORT_E_DATA_OFS;
   localparam logic [7:0] FD  = sgpio_pkg::PORT_F_DATA_OFS;
   localparam logic [7:0] EDR = sgpio_pkg::PORT_E_DIR_OFS;
   localparam logic [7:0] FDR = sgpio_pkg::PORT_F_DIR_OFS;
   logic                     clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, s_en = 1'b0;
   logic [7:0]               addr = 8'h00, wd = 8'h00, rdata, pe_in;
   logic [3:0]               pf_in;
   logic [5:0]               t_en = 6'h00, t_oe = 6'h00, t_in;
   sgpio_pkg::sgpio_spi_t    spi = '0;
   sgpio_pkg::sgpio_e_pins_t pe;
   sgpio_pkg::sgpio_f_pins_t pf;
   int                       error_cnt = 0, compares = 0;
   sgpio_ports sgpio_ports_inst (.CLK(clk), .RESETN(rstn), .CE(1'b1), .ADDR(addr), .WDATA(wd),
      .WR(wr), .RD(rd), .RDATA(rdata), .PE_IN(pe_in), .PE_PINS(pe), .PF_IN(pf_in), .PF_PINS(pf),
      .SPI(spi), .SPI_SCK_IN(), .SPI_MOSI_IN(), .SPI_MISO_IN(), .SPI_SS_N_IN(),
      .SERIAL_ENABLE_BIT(s_en), .SERIAL_TX(1'b0), .SERIAL_RX(), .TIMER_CH_EN(t_en),
      .TIMER_CH_OUT(t_oe), .TIMER_CH_OE(t_oe), .TIMER_CH_IN(t_in));
   sgpio_pins sgpio_pins_inst (.e(pe), .f(pf), .ext_e(8'h5a), .ext_f(4'ha), .e_lvl(pe_in),
      .f_lvl(pf_in));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // one-cycle strobes, released at the edge that takes them
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wd <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata, e);
   endtask : rd_chk
   task automatic tally_and_finish;
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : tally_and_finish
   initial forever #12.5 clk = ~clk;
   // main sequence: plain ports first, then peripherals take pins over
   initial begin
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      rd_chk(FDR, 8'h00);
      rd_chk(ED, 8'h5a);
      wr_reg(ED, 8'ha5);
      rd_chk(ED, 8'h5a);
      wr_reg(EDR, 8'hf0);
      rd_chk(ED, 8'haa);
      chk(pe.oe_n, 8'h0f);
      wr_reg(FD, 8'hc3);
      wr_reg(FDR, 8'h05);
      rd_chk(FD, 8'h0b);
      @(posedge clk);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      wr_reg(FDR, 8'h0f);
      rd_chk(FD, 8'h03);
      wr_reg(EDR, 8'hff);
      spi <= 6'b110100;
      s_en <= 1'b1;
      t_en <= 6'h05;
      t_oe <= 6'h05;
      rd_chk(ED, 8'ha5);
      chk(pe.oe_n, 8'h22);
      @(posedge clk);
      spi <= 6'b100000;
      rd_chk(8'h3f, 8'h00);
      chk(pe.oe_n, 8'hd2);
      @(posedge clk);
      spi <= 6'b111000;
      t_oe <= 6'h00;
      rd_chk(EDR, 8'hff);
      chk(pe.oe_n, 8'h36);
      chk({4'h0, pf.oe_n}, 8'h01);
      chk({4'h0, pf.out}, 8'h02);
      chk({2'h0, t_in}, 8'h08);
      tally_and_finish();
   end
endmodule : sgpio_ports_tb_top
`default_nettype wire
